/* include/task_file_pkg.sv */
// Shared constants and types for the shadow task-file register bank
package task_file_pkg;

    localparam logic [9:0] ADDR_DATA     = 10'h1f0;
    localparam logic [9:0] ADDR_FEATURE  = 10'h1f1;
    localparam logic [9:0] ADDR_COUNT    = 10'h1f2;
    localparam logic [9:0] ADDR_BYTE0    = 10'h1f3;
    localparam logic [9:0] ADDR_BYTE1    = 10'h1f4;
    localparam logic [9:0] ADDR_BYTE2    = 10'h1f5;
    localparam logic [9:0] ADDR_SELECT   = 10'h1f6;
    localparam logic [9:0] ADDR_COMMAND  = 10'h1f7;
    localparam logic [9:0] ADDR_CONTROL  = 10'h3f6;

    // Control register fields
    localparam int CTL_UPPER_SEL  = 7;
    localparam int CTL_SOFT_RESET = 2;
    localparam int CTL_INT_DIS    = 1;
    localparam logic [7:0] CTL_WRITE_MASK = 8'h86;

    // Status register fields
    localparam int ST_BUSY  = 7;
    localparam int ST_READY = 6;
    localparam int ST_DREQ  = 3;
    localparam int ST_ERR   = 0;

    // Select register fields
    localparam int SEL_LBA_MODE = 6;
    localparam int SEL_DRIVE    = 4;

    // Fault code fields
    localparam int ERR_ABORTED = 2;

    localparam logic [7:0] RST_STATUS     = 8'h80;
    localparam logic [7:0] RST_DIAG_CODE  = 8'h01;
    localparam logic [7:0] RST_COUNT      = 8'h01;
    localparam logic [7:0] RST_BYTE0      = 8'h01;
    localparam logic [7:0] RST_BYTE       = 8'h00;
    localparam logic [7:0] RST_SELECT     = 8'h00;
    localparam logic [7:0] RST_CONTROL    = 8'h00;

    // Status bits valid after busy clears
    localparam int STATUS_SETTLE_NS = 400;
    localparam int CLK_PERIOD_NS    = 8;
    localparam int SETTLE_CYCLES    =
        (STATUS_SETTLE_NS / CLK_PERIOD_NS) < 1 ? 1 :
        (STATUS_SETTLE_NS / CLK_PERIOD_NS);

    // Host access from the serial frame layer
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [9:0] addr;
        logic [15:0] wdata;
    } host_access_t;

    // Completion update from command execution
    typedef struct packed {
        logic       done;
        logic       fail;
        logic       abort;
        logic [7:0] diag_code;
        logic       diag_valid;
        logic [15:0] remaining;
        logic [47:0] address;
        logic [3:0] head;
    } completion_t;

    typedef struct packed {
        logic [7:0] cur;
        logic [7:0] prev;
    } byte_pair_t;

endpackage

/* src/ata_shadow_task_file.sv */
// Shadow task-file register bank facing the host through the serial link
`timescale 1ns/1ns

module ata_shadow_task_file
    import task_file_pkg::*;
#(
    parameter int SETTLE = SETTLE_CYCLES
)(
    input  wire logic         i_clk_sys,
    input  wire logic         i_rstn,
    input  wire host_access_t i_host,
    output logic [15:0]       o_rdata,
    input  wire completion_t  i_cmpl,
    input  wire logic         i_exec_ready,
    input  wire logic         i_data_req,
    input  wire logic         i_irq_event,
    input  wire logic         i_fifo_wvalid,
    input  wire logic [15:0]  i_fifo_wdata,
    input  wire logic         i_drive_slot,
    output logic              o_cmd_start,
    output logic [7:0]        o_cmd_code,
    output logic [15:0]       o_sector_count,
    output logic [16:0]       o_sector_count_28,
    output logic [47:0]       o_lba,
    output logic              o_lba_mode,
    output logic [3:0]        o_head_count_m1,
    output logic [15:0]       o_feature,
    output logic [15:0]       o_data_to_dev,
    output logic              o_data_to_dev_stb,
    output logic              o_drive_reset,
    output logic              o_host_interrupt_request_o,
    output logic              o_host_interrupt_request_oe
);

    initial
    begin
        if (SETTLE < 1)
            $error("SETTLE must be at least one cycle");
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers

    logic [7:0]  control_r;
    logic [7:0]  status_r;
    logic [7:0]  fault_r;
    logic [7:0]  select_r;
    logic [7:0]  command_r;
    logic [15:0] data_r;
    byte_pair_t  feature_r;
    byte_pair_t  count_r;
    byte_pair_t  byte0_r;
    byte_pair_t  byte1_r;
    byte_pair_t  byte2_r;
    logic        irq_pending_r;
    logic        ready_hold_r;
    logic        settle_busy_r;
    logic [$clog2(SETTLE+1)-1:0] settle_cnt_r;
    logic        start_r;

    logic wr_cmd;
    logic rd_status;
    logic soft_reset;
    logic busy;

    assign soft_reset = control_r[CTL_SOFT_RESET];
    assign busy       = status_r[ST_BUSY];
    assign wr_cmd     = i_host.wr && (i_host.addr != ADDR_CONTROL);
    // Alternate status read is excluded here on purpose
    assign rd_status  = i_host.rd && (i_host.addr == ADDR_COMMAND);

    ////////////////////////////////////////////////////////////////////////
    // Control block

    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rstn)
            control_r <= RST_CONTROL;
        else if (i_host.wr && i_host.addr == ADDR_CONTROL)
            control_r <= i_host.wdata[7:0] & CTL_WRITE_MASK;
    end

    // Whole drive, both slots, held while the bit stays set
    assign o_drive_reset = !i_rstn || soft_reset;

    ////////////////////////////////////////////////////////////////////////
    // Command block writes; shadow pairs shift on each write accepted while not busy

    function automatic byte_pair_t push(input byte_pair_t p,
                                        input logic [7:0] b);
        push.prev = p.cur;
        push.cur  = b;
    endfunction

    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rstn || soft_reset)
        begin
            feature_r <= '0;
            count_r   <= '{cur: RST_COUNT, prev: 8'h00};
            byte0_r   <= '{cur: RST_BYTE0, prev: 8'h00};
            byte1_r   <= '{cur: RST_BYTE, prev: 8'h00};
            byte2_r   <= '{cur: RST_BYTE, prev: 8'h00};
            select_r  <= RST_SELECT;
        end
        else if (i_cmpl.done)
        begin
            // Completion posts the current address back
            count_r.cur  <= i_cmpl.fail ? i_cmpl.remaining[7:0] : 8'h00;
            count_r.prev <= i_cmpl.fail ? i_cmpl.remaining[15:8] : 8'h00;
            byte0_r.cur  <= i_cmpl.address[7:0];
            byte0_r.prev <= i_cmpl.address[31:24];
            byte1_r.cur  <= i_cmpl.address[15:8];
            byte1_r.prev <= i_cmpl.address[39:32];
            byte2_r.cur  <= i_cmpl.address[23:16];
            byte2_r.prev <= i_cmpl.address[47:40];
            select_r[3:0] <= i_cmpl.head;
        end
        else if (wr_cmd && !busy)
        begin
            case (i_host.addr)
                ADDR_FEATURE: feature_r <= push(feature_r, i_host.wdata[7:0]);
                ADDR_COUNT:   count_r   <= push(count_r, i_host.wdata[7:0]);
                ADDR_BYTE0:   byte0_r   <= push(byte0_r, i_host.wdata[7:0]);
                ADDR_BYTE1:   byte1_r   <= push(byte1_r, i_host.wdata[7:0]);
                ADDR_BYTE2:   byte2_r   <= push(byte2_r, i_host.wdata[7:0]);
                ADDR_SELECT:  select_r  <= i_host.wdata[7:0];
                default:      ;
            endcase
        end
    end

    // Data port: host writes go to the device buffer, device fills reads
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rstn)
            data_r <= 16'h0000;
        else if (i_fifo_wvalid)
            data_r <= i_fifo_wdata;
        else if (wr_cmd && i_host.addr == ADDR_DATA)
            data_r <= i_host.wdata;
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rstn)
            o_data_to_dev_stb <= 1'b0;
        else
            o_data_to_dev_stb <= wr_cmd && i_host.addr == ADDR_DATA;
    end
    assign o_data_to_dev = data_r;

    // Command code write launches execution the next cycle
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rstn || soft_reset)
        begin
            command_r <= 8'h00;
            start_r   <= 1'b0;
        end
        else
        begin
            start_r <= wr_cmd && !busy && i_host.addr == ADDR_COMMAND;
            if (wr_cmd && !busy && i_host.addr == ADDR_COMMAND)
                command_r <= i_host.wdata[7:0];
        end
    end
    assign o_cmd_start = start_r;
    assign o_cmd_code  = command_r;

    ////////////////////////////////////////////////////////////////////////
    // Status and fault code

    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rstn || soft_reset)
            fault_r <= RST_DIAG_CODE;
        else if (i_cmpl.done)
        begin
            if (i_cmpl.diag_valid)
                fault_r <= i_cmpl.diag_code;
            else
            begin
                fault_r <= 8'h00;
                fault_r[ERR_ABORTED] <= i_cmpl.abort;
            end
        end
    end

    // Ready held across an error until the host reads status
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rstn)
            ready_hold_r <= 1'b0;
        else if (i_cmpl.done && (i_cmpl.fail || i_cmpl.abort))
            ready_hold_r <= 1'b1;
        else if (rd_status)
            ready_hold_r <= 1'b0;
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rstn || soft_reset)
            status_r <= RST_STATUS;
        else
        begin
            if (start_r)
                status_r[ST_BUSY] <= 1'b1;
            else if (i_cmpl.done)
            begin
                status_r[ST_BUSY] <= 1'b0;
                status_r[ST_ERR]  <= i_cmpl.fail || i_cmpl.abort;
            end
            else if (status_r[ST_BUSY] && i_exec_ready && !start_r
                     && command_r == 8'h00)
                status_r[ST_BUSY] <= 1'b0;
            if (!ready_hold_r)
                status_r[ST_READY] <= i_exec_ready;
            status_r[ST_DREQ] <= i_data_req;
            status_r[2:1] <= 2'b00;
        end
    end

    // Settle window after each completion; bits read as zero until it ends
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rstn || soft_reset)
        begin
            settle_busy_r <= 1'b0;
            settle_cnt_r  <= '0;
        end
        else if (i_cmpl.done)
        begin
            settle_busy_r <= 1'b1;
            settle_cnt_r  <= '0;
        end
        else if (settle_busy_r)
        begin
            if (settle_cnt_r == ($clog2(SETTLE+1))'(SETTLE - 1))
                settle_busy_r <= 1'b0;
            else
                settle_cnt_r <= settle_cnt_r + 1'b1;
        end
    end

    logic [7:0] status_view;
    always_comb
    begin
        status_view = status_r;
        if (busy || settle_busy_r)
            status_view = {busy, 7'b0000000};
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt

    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rstn || soft_reset)
            irq_pending_r <= 1'b0;
        else if (i_irq_event || i_cmpl.done)
            irq_pending_r <= 1'b1;                       // set wins
        else if (rd_status)
            irq_pending_r <= 1'b0;
    end

    logic drive_selected;
    assign drive_selected = select_r[SEL_DRIVE] == i_drive_slot;
    assign o_host_interrupt_request_oe =
        !control_r[CTL_INT_DIS] && drive_selected;
    assign o_host_interrupt_request_o =
        o_host_interrupt_request_oe && irq_pending_r;

    ////////////////////////////////////////////////////////////////////////
    // Read mux

    function automatic logic [7:0] pick(input byte_pair_t p,
                                        input logic hi);
        pick = hi ? p.prev : p.cur;
    endfunction

    logic hi_sel;
    assign hi_sel = control_r[CTL_UPPER_SEL];

    always_ff @(posedge i_clk_sys)
    begin
        if (!i_rstn)
            o_rdata <= 16'h0000;
        else if (i_host.rd)
        begin
            if (i_host.addr == ADDR_CONTROL)
                o_rdata <= {8'h00, status_view};
            else if (busy)
                o_rdata <= {8'h00, status_view};
            else
            begin
                case (i_host.addr)
                    ADDR_DATA:    o_rdata <= data_r;
                    ADDR_FEATURE: o_rdata <= {8'h00, fault_r};
                    ADDR_COUNT:   o_rdata <= {8'h00, pick(count_r, hi_sel)};
                    ADDR_BYTE0:   o_rdata <= {8'h00, pick(byte0_r, hi_sel)};
                    ADDR_BYTE1:   o_rdata <= {8'h00, pick(byte1_r, hi_sel)};
                    ADDR_BYTE2:   o_rdata <= {8'h00, pick(byte2_r, hi_sel)};
                    ADDR_SELECT:  o_rdata <= {8'h00, select_r};
                    ADDR_COMMAND: o_rdata <= {8'h00, status_view};
                    default:      o_rdata <= 16'h0000;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Decoded parameters for command execution

    assign o_lba_mode     = select_r[SEL_LBA_MODE];
    assign o_feature      = {feature_r.prev, feature_r.cur};
    assign o_sector_count = {count_r.prev, count_r.cur};
    assign o_sector_count_28 = (count_r.cur == 8'h00) ?
        17'd256 : {9'h000, count_r.cur};
    assign o_lba = o_lba_mode ?
        {byte2_r.prev, byte1_r.prev, byte0_r.prev,
         byte2_r.cur, byte1_r.cur, byte0_r.cur} :
        {20'h00000, select_r[3:0], byte2_r.cur, byte1_r.cur,
         byte0_r.cur};
    assign o_head_count_m1 = select_r[3:0];

endmodule // ata_shadow_task_file

/* bench/task_file_properties.sv */
// Concurrent checks on the task-file bank ports
`timescale 1ns/1ns

module task_file_properties
    import task_file_pkg::*;
(
    input  wire logic         i_clk_sys,
    input  wire logic         i_rstn,
    input  wire host_access_t i_host,
    input  wire completion_t  i_cmpl,
    input  wire logic         i_irq_event,
    input  wire logic [15:0]  o_rdata,
    input  wire logic         o_cmd_start,
    input  wire logic [7:0]   o_cmd_code,
    input  wire logic [15:0]  o_sector_count,
    input  wire logic [16:0]  o_sector_count_28,
    input  wire logic [15:0]  o_data_to_dev,
    input  wire logic         o_data_to_dev_stb,
    input  wire logic         o_drive_reset,
    input  wire logic         o_host_interrupt_request_o,
    input  wire logic         o_host_interrupt_request_oe
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rstn);

    ////////////////////////////////////////////////////////////////////////
    a_cmd_from_write: assert property (o_cmd_start |-> $past(i_host.wr)
        && $past(i_host.addr) == ADDR_COMMAND
        && o_cmd_code == $past(i_host.wdata[7:0]))
        else $error("command start without command write");
    a_irq_gated: assert property (o_host_interrupt_request_o
        |-> o_host_interrupt_request_oe)
        else $error("interrupt driven while released");
    a_irq_disable: assert property (i_host.wr
        && i_host.addr == ADDR_CONTROL && i_host.wdata[CTL_INT_DIS]
        |=> !o_host_interrupt_request_oe)
        else $error("interrupt enabled after disable write");
    a_count_28_map: assert property (o_sector_count_28 ==
        ((o_sector_count[7:0] == 8'h00) ? 17'h00100
        : {9'h000, o_sector_count[7:0]}))
        else $error("28-bit count mapping wrong");
    a_data_strobe: assert property (o_data_to_dev_stb
        |-> $past(i_host.wr) && $past(i_host.addr) == ADDR_DATA
        && o_data_to_dev == $past(i_host.wdata))
        else $error("data strobe without matching write");
    a_status_ack: assert property (i_host.rd
        && i_host.addr == ADDR_COMMAND && !i_irq_event && !i_cmpl.done
        |=> !o_host_interrupt_request_o)
        else $error("status read left interrupt pending");
    a_alt_no_ack: assert property (i_host.rd && !i_host.wr
        && i_host.addr == ADDR_CONTROL && o_host_interrupt_request_o
        |=> o_host_interrupt_request_o)
        else $error("alternate status read cleared interrupt");
    a_unmapped_zero: assert property (i_host.rd
        && i_host.addr[9:4] == 6'h00 |=> o_rdata == 16'h0000)
        else $error("unmapped read not zero");
    a_upper_zero: assert property (i_host.rd
        && i_host.addr != ADDR_DATA |=> o_rdata[15:8] == 8'h00)
        else $error("byte register read has upper bits");
    a_soft_reset: assert property (i_host.wr
        && i_host.addr == ADDR_CONTROL
        |=> o_drive_reset == $past(i_host.wdata[CTL_SOFT_RESET]))
        else $error("soft reset output does not follow control");

    c_cmd: cover property (o_cmd_start);
    c_fail: cover property (i_cmpl.done && i_cmpl.fail);
    c_irq: cover property (o_host_interrupt_request_o);
    c_data: cover property (o_data_to_dev_stb);
endmodule // task_file_properties

bind ata_shadow_task_file task_file_properties u_props (
    .i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_host(i_host),
    .i_cmpl(i_cmpl), .i_irq_event(i_irq_event),
    .o_rdata(o_rdata), .o_cmd_start(o_cmd_start), .o_cmd_code(o_cmd_code),
    .o_sector_count(o_sector_count), .o_sector_count_28(o_sector_count_28),
    .o_data_to_dev(o_data_to_dev), .o_data_to_dev_stb(o_data_to_dev_stb),
    .o_drive_reset(o_drive_reset),
    .o_host_interrupt_request_o(o_host_interrupt_request_o),
    .o_host_interrupt_request_oe(o_host_interrupt_request_oe));

/* bench/host_model.sv */
// Host-side register access model for the task-file bus
`timescale 1ns/1ns

module host_model
    import task_file_pkg::*;
(
    input  wire logic        i_clk_sys,
    input  wire logic [15:0] i_rdata,
    output host_access_t     o_host
);
    initial o_host = '0;

    // Released lines carry inverted junk so stale values never match
    task automatic write_reg(input logic [9:0] a, input logic [15:0] d);
        @(posedge i_clk_sys);
        o_host <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
        @(posedge i_clk_sys);
        o_host <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
        // Return where the write has landed in the bank
        @(negedge i_clk_sys);
    endtask

    task automatic read_reg(input logic [9:0] a, output logic [15:0] d);
        @(posedge i_clk_sys);
        o_host <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 16'h5a5a};
        @(posedge i_clk_sys);
        o_host <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: 16'ha5a5};
        @(negedge i_clk_sys);
        d = i_rdata;
    endtask
endmodule // host_model

/* bench/ata_shadow_task_file_test.sv */
// Self-checking bench for the shadow task-file register bank
`timescale 1ns/1ns

module ata_shadow_task_file_test
    import task_file_pkg::*;
;
    localparam int SET = 4;
    logic         i_clk_sys = 1'b0;
    logic         i_rstn = 1'b0;
    host_access_t i_host;
    completion_t  i_cmpl = '0;
    logic         i_exec_ready = 1'b0;
    logic         i_data_req = 1'b0;
    logic         i_irq_event = 1'b0;
    logic         i_drive_slot = 1'b0;
    logic         fifo_v = 1'b0;
    logic [15:0]  fifo_d = 16'h0000;
    logic [15:0]  o_rdata, o_sector_count, o_feature, o_data_to_dev;
    logic [16:0]  o_sector_count_28;
    logic [47:0]  o_lba, adr;
    logic [7:0]   o_cmd_code, diag;
    logic [3:0]   o_head_count_m1, hd;
    logic         o_cmd_start, o_lba_mode, o_data_to_dev_stb, o_drive_reset;
    logic         irq_o, irq_oe;
    logic [7:0]   v0 [1:5];
    logic [7:0]   v1 [1:5];
    logic [15:0]  st, sel, rem;
    int           n_fail = 0;
    int           n_checks = 0;
    int           seed = 32'h057f;

    always #4 i_clk_sys = ~i_clk_sys;

    host_model host (.i_clk_sys(i_clk_sys), .i_rdata(o_rdata),
        .o_host(i_host));

    ata_shadow_task_file #(.SETTLE(SET)) dut (
        .i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_host(i_host),
        .o_rdata(o_rdata), .i_cmpl(i_cmpl), .i_exec_ready(i_exec_ready),
        .i_data_req(i_data_req), .i_irq_event(i_irq_event),
        .i_fifo_wvalid(fifo_v), .i_fifo_wdata(fifo_d),
        .i_drive_slot(i_drive_slot), .o_cmd_start(o_cmd_start),
        .o_cmd_code(o_cmd_code), .o_sector_count(o_sector_count),
        .o_sector_count_28(o_sector_count_28), .o_lba(o_lba),
        .o_lba_mode(o_lba_mode), .o_head_count_m1(o_head_count_m1),
        .o_feature(o_feature), .o_data_to_dev(o_data_to_dev),
        .o_data_to_dev_stb(o_data_to_dev_stb), .o_drive_reset(o_drive_reset),
        .o_host_interrupt_request_o(irq_o),
        .o_host_interrupt_request_oe(irq_oe));

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] stat(input logic b, r, q, e);
        return {8'h00, b, r, 2'b00, q, 2'b00, e};
    endfunction

    function automatic logic [16:0] cnt28(input logic [7:0] c);
        return (c == 8'h00) ? 17'h00100 : {9'h000, c};
    endfunction

    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic rdc(input logic [9:0] a, input logic [15:0] e);
        logic [15:0] d;
        host.read_reg(a, d);
        chk(d, e);
    endtask

    task automatic ctl(input logic [7:0] v);
        host.write_reg(ADDR_CONTROL, {8'h00, v});
        @(negedge i_clk_sys);
    endtask

    // Settle wait avoids reading status bits while they are still invalid
    task automatic finish_cmd(input logic f, ab, dv, input logic [15:0] r);
        @(posedge i_clk_sys);
        i_cmpl <= '{done: 1'b1, fail: f, abort: ab, diag_code: diag,
            diag_valid: dv, remaining: r, address: adr, head: hd};
        @(posedge i_clk_sys);
        i_cmpl.done <= 1'b0;
        repeat (SET + 2) @(posedge i_clk_sys);
        @(negedge i_clk_sys);
    endtask

    initial
    begin
        repeat (20000) @(posedge i_clk_sys);
        n_fail++;
        stop_test();
    end

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (2) @(posedge i_clk_sys);
        i_rstn <= 1'b1;
        rdc(ADDR_COMMAND, 16'h0080);
        rdc(ADDR_FEATURE, 16'h0080);
        i_exec_ready <= 1'b1;
        adr[31:0] = $random(seed);
        adr[47:32] = 16'($random(seed));
        hd = 4'($random(seed));
        diag = 8'($random(seed));
        finish_cmd(1'b0, 1'b0, 1'b1, 16'h0000);
        chk(irq_o, 1'b1);
        rdc(ADDR_CONTROL, stat(0, 1, 0, 0));
        chk(irq_o, 1'b1);
        rdc(ADDR_COMMAND, stat(0, 1, 0, 0));
        chk(irq_o, 1'b0);
        rdc(ADDR_FEATURE, {8'h00, diag});
        rdc(ADDR_COUNT, 16'h0000);
        rdc(ADDR_BYTE0, {8'h00, adr[7:0]});
        rdc(ADDR_BYTE1, {8'h00, adr[15:8]});
        rdc(ADDR_BYTE2, {8'h00, adr[23:16]});
        rdc(ADDR_SELECT, {12'h000, hd});
        chk(o_lba, {20'h00000, hd, adr[23:0]});
        rdc(10'h005, 16'h0000);
        host.write_reg(ADDR_SELECT, 16'h0040);
        for (int i = 1; i <= 5; i++)
        begin
            v0[i] = 8'($random(seed));
            v1[i] = (i == 2) ? 8'h00 : 8'($random(seed));
            host.write_reg(ADDR_DATA + 10'(i), {8'h00, v0[i]});
            host.write_reg(ADDR_DATA + 10'(i), {8'h00, v1[i]});
        end
        chk(o_feature, {v0[1], v1[1]});
        chk(o_sector_count, {v0[2], v1[2]});
        chk(o_sector_count_28, cnt28(v1[2]));
        chk(o_lba, {v0[5], v0[4], v0[3], v1[5], v1[4], v1[3]});
        for (int h = 0; h < 2; h++)
        begin
            ctl((h == 1) ? 8'h80 : 8'h00);
            for (int i = 2; i <= 5; i++)
                rdc(ADDR_DATA + 10'(i), {8'h00, h ? v0[i] : v1[i]});
        end
        ctl(8'h00);
        sel = {9'h000, 1'($random(seed)), 2'b00, 4'($random(seed))};
        host.write_reg(ADDR_SELECT, sel);
        chk(o_lba_mode, sel[SEL_LBA_MODE]);
        chk(o_head_count_m1, sel[3:0]);
        rdc(ADDR_SELECT, sel);
        st = 16'($random(seed));
        host.write_reg(ADDR_DATA, st);
        chk(o_data_to_dev_stb, 1'b1);
        chk(o_data_to_dev, st);
        @(posedge i_clk_sys);
        fifo_v <= 1'b1;
        fifo_d <= 16'($random(seed));
        @(posedge i_clk_sys);
        fifo_v <= 1'b0;
        rdc(ADDR_DATA, fifo_d);
        @(posedge i_clk_sys);
        i_irq_event <= 1'b1;
        @(posedge i_clk_sys);
        i_irq_event <= 1'b0;
        @(negedge i_clk_sys);
        chk(irq_o, 1'b1);
        ctl(8'h02);
        chk(irq_oe, 1'b0);
        ctl(8'h00);
        i_drive_slot <= 1'b1;
        @(negedge i_clk_sys);
        chk(irq_oe, 1'b0);
        i_drive_slot <= 1'b0;
        rdc(ADDR_COMMAND, stat(0, 1, 0, 0));
        host.write_reg(ADDR_COMMAND, 16'h00c8);
        chk(o_cmd_start, 1'b1);
        chk(o_cmd_code, 8'hc8);
        host.read_reg(ADDR_COMMAND, st);
        chk(st[ST_BUSY], 1'b1);
        rdc(ADDR_COUNT, st);
        rem = 16'($random(seed)) | 16'h0001;
        i_data_req <= 1'b1;
        finish_cmd(1'b1, 1'b1, 1'b0, rem);
        // Readiness drops after the error; status must keep the old value
        i_exec_ready <= 1'b0;
        rdc(ADDR_COUNT, {8'h00, rem[7:0]});
        rdc(ADDR_FEATURE, 16'h0004);
        rdc(ADDR_CONTROL, stat(0, 1, 1, 1));
        rdc(ADDR_COMMAND, stat(0, 1, 1, 1));
        rdc(ADDR_COMMAND, stat(0, 0, 1, 1));
        ctl(8'h80);
        rdc(ADDR_COUNT, {8'h00, rem[15:8]});
        ctl(8'h04);
        chk(o_drive_reset, 1'b1);
        rdc(ADDR_COMMAND, 16'h0080);
        ctl(8'h00);
        chk(o_drive_reset, 1'b0);
        rdc(ADDR_COUNT, 16'h0080);
        stop_test();
    end
endmodule // ata_shadow_task_file_test
